// [conv_mode_pkg.sv]
// Package with register layout, mode codes and carrier types for the input conversion mode block.
package conv_mode_pkg;

    localparam logic [3:0] REG_MODE_OFFSET = 4'h0;
    localparam logic [3:0] REG_SIZE_OFFSET = 4'h4;
    localparam logic [3:0] REG_STATUS_OFFSET = 4'h8;

    localparam int BIT_MODE2 = 4;
    localparam int BIT_MEM_SWAP = 3;
    localparam int BIT_PORT_SWAP = 2;
    localparam int BIT_MODE1 = 1;
    localparam int BIT_MODE0 = 0;

    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] MODE_WRITE_MASK = 16'h001F;

    typedef enum logic [2:0]
    {
        MODE_NORMAL = 3'b000,
        MODE_YUV = 3'b001,
        MODE_DYUV = 3'b010,
        MODE_PASS16 = 3'b011,
        MODE_STEP8 = 3'b100,
        MODE_BAD5 = 3'b101,
        MODE_BAD6 = 3'b110,
        MODE_PASS8 = 3'b111
    } conv_mode_t;

    typedef struct packed
    {
        logic valid;
        logic [15:0] data;
    } word_t;

endpackage : conv_mode_pkg

// [byte_swapper.sv]
// Conditional exchange of the two bytes of a 16-bit word.
`timescale 1ns/1ps
`default_nettype none
module byte_swapper
(
    input wire logic swap_i,
    input wire logic [15:0] word_i,
    output logic [15:0] word_o
);
    always_comb
    begin
        word_o = swap_i ? {word_i[7:0], word_i[15:8]} : word_i;
    end
endmodule : byte_swapper
`default_nettype wire

// [pixel_counter.sv]
// Down counter of remaining pixels for a conversion run.
`timescale 1ns/1ps
`default_nettype none
module pixel_counter
#(
    parameter int WIDTH = 32
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_value_i,
    input wire logic dec_i,
    output logic [WIDTH-1:0] count_o,
    output logic last_o
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    always_comb
    begin
        count_next = count_reg;
        if (load_i)
        begin
            count_next = load_value_i;
        end
        else if (dec_i && count_reg != '0)
        begin
            count_next = count_reg - WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_reg <= '0;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    assign count_o = count_reg;
    assign last_o = dec_i && (count_reg == WIDTH'(1));
endmodule : pixel_counter
`default_nettype wire

// [input_data_conversion_mode.sv]
// Input conversion mode register with byte-swap steering on the memory and image port write paths.
// Operation
// RULE1: Software should not rewrite the mode register while a conversion runs, else behaviour is unstable for a while.
// RULE2: Reset clears every mode register bit, the mode field and both swap bits included.
// RULE3: Software writes zero into the reserved bits 15 to 5 of the mode register.
// RULE4: The three-bit mode field at bits 4, 1 and 0 selects whether input data is converted to RGB before storage.
// RULE5: The memory-write swap bit 3 acts only when the mode is 000 and the DMA mode bits are 00 or 01.
// RULE6: An active memory-write swap exchanges the two bytes of each 16-bit host word write to memory.
// RULE7: The memory-write swap never touches register writes or memory reads.
// RULE8: The image-port swap bit 2 acts only for modes 001, 010, 011 or 111 with DMA mode bits 00 or 11.
// RULE9: An active image-port swap exchanges the two bytes of each 16-bit word through the image entry port.
// RULE10: Mode 000 is normal operation with no image entry port transfers.
// RULE11: Modes 001, 010 and 011 load width times height pixels, count down per pixel and self-clear to 000 at zero.
// RULE12: For mode 111 software gives the width as transfer words and reaches the mode through 100.
// RULE13: Software never sets modes 101 or 110; 100 precedes 111 and 000 precedes 011.
// RULE14: A read returns the stored mode register with reserved bits as zero.
`timescale 1ns/1ps
`default_nettype none
module input_data_conversion_mode
#(
    parameter int DIM_WIDTH = 16
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // DMA mode from the transfer controller.
    input wire logic [1:0] dma_mode_i,
    // Host word write toward graphics memory.
    input wire conv_mode_pkg::word_t mem_wr_i,
    output conv_mode_pkg::word_t mem_wr_o,
    // Host word read from graphics memory, passed unchanged.
    input wire conv_mode_pkg::word_t mem_rd_i,
    output conv_mode_pkg::word_t mem_rd_o,
    // Image entry port words, one per processed pixel.
    input wire conv_mode_pkg::word_t image_entry_port_i,
    output conv_mode_pkg::word_t image_entry_port_o,
    output logic [2:0] conv_mode_o,
    output logic busy_o
);
    localparam int CNT_W = 2 * DIM_WIDTH;

    initial
    begin
        if (DIM_WIDTH < 1 || DIM_WIDTH > 16)
        begin
            $error("DIM_WIDTH must lie between 1 and 16");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [15:0] mode_reg;
    logic [15:0] mode_next;
    logic [DIM_WIDTH-1:0] width_reg;
    logic [DIM_WIDTH-1:0] width_next;
    logic [DIM_WIDTH-1:0] height_reg;
    logic [DIM_WIDTH-1:0] height_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    logic [2:0] mode_field;
    logic bus_req;
    logic wr_mode;
    logic wr_size;
    logic cnt_load;
    logic cnt_last;
    logic [CNT_W-1:0] cnt_value;
    logic running;
    logic mem_swap_en;
    logic port_swap_en;
    logic port_pixel;
    logic [15:0] mem_swapped;
    logic [15:0] port_swapped;

    // RULE4
    assign mode_field = {mode_reg[conv_mode_pkg::BIT_MODE2], mode_reg[conv_mode_pkg::BIT_MODE1],
                         mode_reg[conv_mode_pkg::BIT_MODE0]};

    // A new request only starts while no ack is pending, giving one ack per classic cycle.
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_mode = bus_req && wb_we_i && (wb_adr_i == conv_mode_pkg::REG_MODE_OFFSET) && wb_sel_i[0];
    assign wr_size = bus_req && wb_we_i && (wb_adr_i == conv_mode_pkg::REG_SIZE_OFFSET);

    // RULE11
    assign running = (mode_field == conv_mode_pkg::MODE_YUV) || (mode_field == conv_mode_pkg::MODE_DYUV)
                     || (mode_field == conv_mode_pkg::MODE_PASS16) || (mode_field == conv_mode_pkg::MODE_PASS8);

    ////////////////////////////////////////////////////////////////////////////////
    // Pixel count, loaded when a write enters a counting mode from a non-counting one.

    always_comb
    begin
        cnt_load = 1'b0;
        if (wr_mode && !running)
        begin
            case (conv_mode_pkg::conv_mode_t'({wb_dat_i[conv_mode_pkg::BIT_MODE2], wb_dat_i[conv_mode_pkg::BIT_MODE1],
                                               wb_dat_i[conv_mode_pkg::BIT_MODE0]}))
                conv_mode_pkg::MODE_YUV,
                conv_mode_pkg::MODE_DYUV,
                conv_mode_pkg::MODE_PASS16,
                conv_mode_pkg::MODE_PASS8: cnt_load = 1'b1; // RULE11
                default: cnt_load = 1'b0;
            endcase
        end
    end

    // RULE10
    assign port_pixel = running && image_entry_port_i.valid;

    pixel_counter #(
        .WIDTH(CNT_W)
    ) u_pixel_counter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(cnt_load),
        .load_value_i(CNT_W'(width_reg) * CNT_W'(height_reg)),
        .dec_i(port_pixel),
        .count_o(cnt_value),
        .last_o(cnt_last)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register file next state.

    always_comb
    begin
        mode_next = mode_reg;
        width_next = width_reg;
        height_next = height_reg;
        ack_next = bus_req;
        rdata_next = 32'h0000_0000;
        if (wr_mode)
        begin
            // Reserved bits are dropped even if software violates the zero-write convention.
            mode_next = wb_dat_i[15:0] & conv_mode_pkg::MODE_WRITE_MASK; // RULE3
        end
        if (wr_size)
        begin
            if (wb_sel_i[1:0] != 2'b00)
            begin
                width_next = wb_dat_i[DIM_WIDTH-1:0];
            end
            if (wb_sel_i[3:2] != 2'b00)
            begin
                height_next = wb_dat_i[16+DIM_WIDTH-1:16];
            end
        end
        // The hardware clear wins over a software write in the same cycle so the run ends cleanly.
        if (cnt_last)
        begin
            mode_next[conv_mode_pkg::BIT_MODE2] = 1'b0; // RULE11
            mode_next[conv_mode_pkg::BIT_MODE1] = 1'b0;
            mode_next[conv_mode_pkg::BIT_MODE0] = 1'b0;
        end
        if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
                conv_mode_pkg::REG_MODE_OFFSET: rdata_next = {16'h0000, mode_reg & conv_mode_pkg::MODE_WRITE_MASK}; // RULE14
                conv_mode_pkg::REG_SIZE_OFFSET: rdata_next = {16'(height_reg), 16'(width_reg)};
                conv_mode_pkg::REG_STATUS_OFFSET: rdata_next = 32'(cnt_value);
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_reg <= conv_mode_pkg::MODE_RESET; // RULE2
            width_reg <= '0;
            height_reg <= '0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            mode_reg <= mode_next;
            width_reg <= width_next;
            height_reg <= height_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data paths.

    always_comb
    begin
        mem_swap_en = mode_reg[conv_mode_pkg::BIT_MEM_SWAP] && (mode_field == conv_mode_pkg::MODE_NORMAL)
                      && (dma_mode_i == 2'b00 || dma_mode_i == 2'b01); // RULE5
        port_swap_en = mode_reg[conv_mode_pkg::BIT_PORT_SWAP] && running
                       && (dma_mode_i == 2'b00 || dma_mode_i == 2'b11); // RULE8
    end

    byte_swapper u_mem_swap (
        .swap_i(mem_swap_en), // RULE6
        .word_i(mem_wr_i.data),
        .word_o(mem_swapped)
    );

    byte_swapper u_port_swap (
        .swap_i(port_swap_en), // RULE9
        .word_i(image_entry_port_i.data),
        .word_o(port_swapped)
    );

    conv_mode_pkg::word_t mem_wr_reg;
    conv_mode_pkg::word_t mem_wr_next;
    conv_mode_pkg::word_t mem_rd_reg;
    conv_mode_pkg::word_t mem_rd_next;
    conv_mode_pkg::word_t port_reg;
    conv_mode_pkg::word_t port_next;
    logic [2:0] mode_out_reg;
    logic busy_reg;

    always_comb
    begin
        mem_wr_next = '{valid: mem_wr_i.valid, data: mem_swapped};
        mem_rd_next = mem_rd_i; // RULE7
        port_next = '{valid: port_pixel, data: port_swapped}; // RULE10
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_wr_reg <= '0;
            mem_rd_reg <= '0;
            port_reg <= '0;
            mode_out_reg <= 3'b000;
            busy_reg <= 1'b0;
        end
        else
        begin
            mem_wr_reg <= mem_wr_next;
            mem_rd_reg <= mem_rd_next;
            port_reg <= port_next;
            mode_out_reg <= mode_next[4] ? {1'b1, mode_next[1:0]} : {1'b0, mode_next[1:0]};
            busy_reg <= cnt_load || (running && !cnt_last);
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign mem_wr_o = mem_wr_reg;
    assign mem_rd_o = mem_rd_reg;
    assign image_entry_port_o = port_reg;
    assign conv_mode_o = mode_out_reg;
    assign busy_o = busy_reg;
endmodule : input_data_conversion_mode
`default_nettype wire

// [conv_mode_asserts.sv]
// Port checker for the input conversion mode block.
`timescale 1ns/1ps
`default_nettype none
module conv_mode_asserts
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] dma_mode_i,
    input wire conv_mode_pkg::word_t mem_wr_i,
    input wire conv_mode_pkg::word_t mem_wr_o,
    input wire conv_mode_pkg::word_t mem_rd_i,
    input wire conv_mode_pkg::word_t mem_rd_o,
    input wire conv_mode_pkg::word_t image_entry_port_i,
    input wire conv_mode_pkg::word_t image_entry_port_o,
    input wire logic [2:0] conv_mode_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_run_end;
        busy_o ##1 !busy_o;
    endsequence
    property p_ack;
        s_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    // Read data was loaded one edge earlier, so it shows the mode field of that edge.
    property p_rd_mode;
        wb_ack_o && !wb_we_i && wb_adr_i == conv_mode_pkg::REG_MODE_OFFSET
            |-> wb_dat_o[31:5] == 27'h0 && {wb_dat_o[4], wb_dat_o[1:0]} == $past(conv_mode_o);
    endproperty
    property p_reset;
        $fell(rst_i) |-> conv_mode_o == 3'h0 && !busy_o && !wb_ack_o;
    endproperty
    property p_mem_plain;
        mem_wr_i.valid && (conv_mode_o != 3'h0 || dma_mode_i[1]) |=> mem_wr_o == $past(mem_wr_i);
    endproperty
    property p_mem_rd;
        mem_rd_i.valid |=> mem_rd_o == $past(mem_rd_i);
    endproperty
    property p_port_plain;
        image_entry_port_i.valid && busy_o && dma_mode_i inside {2'h1, 2'h2}
            |=> image_entry_port_o == $past(image_entry_port_i);
    endproperty
    property p_idle_port;
        conv_mode_o == 3'h0 && $past(conv_mode_o) == 3'h0 |-> !image_entry_port_o.valid;
    endproperty
    property p_busy_mode;
        busy_o |-> conv_mode_o inside {3'h1, 3'h2, 3'h3, 3'h7};
    endproperty
    property p_run_end;
        s_run_end |-> conv_mode_o == 3'h0;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing or too long");
    a_rd_mode: assert property (p_rd_mode) else $error("mode read data wrong");
    a_reset: assert property (p_reset) else $error("state not clear after reset");
    a_mem_plain: assert property (p_mem_plain) else $error("memory word swapped");
    a_mem_rd: assert property (p_mem_rd) else $error("memory read altered");
    a_port_plain: assert property (p_port_plain) else $error("port word swapped");
    a_idle_port: assert property (p_idle_port) else $error("port word in normal mode");
    a_busy_mode: assert property (p_busy_mode) else $error("busy in non counting mode");
    a_run_end: assert property (p_run_end) else $error("mode not cleared at run end");
endmodule : conv_mode_asserts
bind input_data_conversion_mode conv_mode_asserts chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .dma_mode_i, .mem_wr_i, .mem_wr_o, .mem_rd_i, .mem_rd_o,
    .image_entry_port_i, .image_entry_port_o, .conv_mode_o, .busy_o);
`default_nettype wire

// [host_model.sv]
// Host processor model: Wishbone master and word sources.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    input wire logic clk_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i,
    output conv_mode_pkg::word_t mem_wr_o,
    output conv_mode_pkg::word_t mem_rd_o,
    output conv_mode_pkg::word_t pix_o
);
    initial
    begin
        {cyc_o, stb_o, we_o, adr_o, dat_o, mem_wr_o, mem_rd_o, pix_o} = '0;
    end
    task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h3, we, adr, wd};
        do
            @(posedge clk_i);
        while (ack_i !== 1'b1);
        rd = dat_i;
        {cyc_o, stb_o, we_o} <= 3'h0;
        dat_o <= ~wd;
        @(posedge clk_i);
    endtask : bus
    // A released word line shows the inverted data so stale values never look valid.
    // The valid word stands for exactly one rising edge; the caller may then look at the registered copy.
    task automatic word(input int k, input logic [15:0] d);
        conv_mode_pkg::word_t w;
        for (int i = 0; i < 2; i++)
        begin
            w = {i == 0, i == 0 ? d : ~d};
            case (k)
                0: mem_wr_o <= w;
                1: mem_rd_o <= w;
                default: pix_o <= w;
            endcase
            if (i == 0)
            begin
                @(posedge clk_i);
            end
        end
    endtask : word
endmodule : host_model
`default_nettype wire

// [tb.sv]
// Self-checking testbench of the input conversion mode block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i, rst_i, cyc, stb, we, ack, busy;
    logic [3:0] adr;
    logic [31:0] dw, dr, rd;
    logic [1:0] dma = 2'h0;
    logic [2:0] mode;
    logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
    conv_mode_pkg::word_t mw, mwo, mr, mro, px, pxo;
    int mismatches = 0;
    int n_checks = 0;
    input_data_conversion_mode dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .dma_mode_i(dma),
        .mem_wr_i(mw), .mem_wr_o(mwo), .mem_rd_i(mr), .mem_rd_o(mro), .image_entry_port_i(px),
        .image_entry_port_o(pxo), .conv_mode_o(mode), .busy_o(busy));
    host_model host_u (.clk_i, .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(dw), .dat_i(dr),
        .ack_i(ack), .mem_wr_o(mw), .mem_rd_o(mr), .pix_o(px));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic report_and_stop;
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // Sends one word with the given DMA mode and compares the registered copy at the next negedge.
    task automatic xw(input int k, input logic [15:0] d, input logic [1:0] m, input logic [16:0] e, input string n);
        dma <= m;
        host_u.word(k, d);
        @(negedge clk_i);
        chk(n, k == 0 ? mwo : k == 1 ? mro : pxo, e);
        @(posedge clk_i);
    endtask : xw
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        host_u.bus(1'b0, conv_mode_pkg::REG_MODE_OFFSET, 32'h0, rd);
        chk("mode reset", rd, 32'h0);
        host_u.bus(1'b0, 4'hC, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        xw(0, 16'hA1B2, 2'h0, 17'h1A1B2, "mem swap off");
        host_u.bus(1'b1, conv_mode_pkg::REG_MODE_OFFSET, 32'h0008, rd);
        host_u.bus(1'b0, conv_mode_pkg::REG_MODE_OFFSET, 32'h0, rd);
        chk("swap bit", rd, 32'h0008);
        for (int i = 0; i < 4; i++)
            xw(0, 16'hA1B2, i[1:0], i < 2 ? 17'h1B2A1 : 17'h1A1B2, "mem swap");
        xw(1, 16'hA1B2, 2'h0, 17'h1A1B2, "mem read");
        // Each run starts from normal mode, or from mode 100 for the 111 run, and is never rewritten while it counts.
        for (int k = 0; k < 4; k++)
        begin
            host_u.bus(1'b1, conv_mode_pkg::REG_SIZE_OFFSET, 32'h0001_0002, rd);
            if (codes[k] == 3'h7)
                host_u.bus(1'b1, conv_mode_pkg::REG_MODE_OFFSET, 32'h0010, rd);
            host_u.bus(1'b1, conv_mode_pkg::REG_MODE_OFFSET, {27'h0, codes[k][2], 2'h3, codes[k][1:0]}, rd);
            chk("mode field", mode, codes[k]);
            xw(0, 16'h1234, 2'h0, 17'h11234, "mem in run");
            xw(2, 16'h1234, 2'h1, 17'h11234, "port kept");
            chk("busy", busy, 32'h1);
            xw(2, 16'h5678, 2'h3, 17'h17856, "port swap");
            host_u.bus(1'b0, conv_mode_pkg::REG_MODE_OFFSET, 32'h0, rd);
            chk("self clear", rd, 32'h000C);
        end
        xw(2, 16'h5678, 2'h0, 17'h05678, "port idle");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
